// >>> hw/cpsc_top.sv
/*
 * Codec port slot configuration: AHB-Lite register slave, AC-link slot 0
 * tag transmit and codec-ready capture, I2S mode 5 receive slot framing.
 * Assumes one AHB-Lite master, bit clock far slower than clk_i.
 */
// Register access over AHB-Lite was decided locally.
// Function
// - valid-slot/ready byte acts on the port only in the AC-link mode
// - valid-frame bit set marks the frame valid in the sent slot 0 tag
// - valid-frame bit clear clears only tag bit 15; slot tag bits are still sent
// - each frame, incoming slot 0 bit 15 copied to per-codec ready flags
// - high byte bits 4:0 tag slots 3 to 7 in the outgoing frame
// - low byte bits 7:3 tag slots 8 to 12, giving flags for 3..12
`timescale 1ns/10ps
`include "cpsc_defs.svh"
module cpsc_top
    import cpsc_pkg::*;
(
    input wire logic clk_i, // 25 MHz block clock
    input wire logic reset_i, // async reset, high
    input wire logic hsel_i, // AHB slave select
    input wire logic [31:0] haddr_i, // AHB address
    input wire logic [1:0] htrans_i, // AHB transfer type
    input wire logic hwrite_i, // AHB write
    input wire logic [2:0] hsize_i, // AHB size, word only
    input wire logic [31:0] hwdata_i, // AHB write data
    input wire logic hready_i, // AHB bus ready
    output logic [31:0] hrdata_o, // AHB read data
    output logic hreadyout_o, // AHB slave ready
    output logic hresp_o, // AHB response, always OKAY
    output logic irq_o, // level interrupt
    input wire logic link_bclk_i, // codec serial clock
    input wire logic link_sdi_pri_i, // serial in, primary codec
    input wire logic link_sdi_sec_i, // serial in, secondary codec
    output logic link_sync_o, // frame sync out
    output logic link_sdo_o // serial data out
);
    function automatic cpsc_reg_e cpsc_decode(input logic [31:0] a);
        cpsc_reg_e r;
        r = CPSC_REG_NONE;
        if (a[31:18] == 14'h0000 && a[1:0] == 2'h0)
        begin
            case (a[17:2])
                `CPSC_IDX_RXFMT: r = CPSC_REG_RXFMT;
                `CPSC_IDX_VSLH: r = CPSC_REG_VSLH;
                `CPSC_IDX_VSLL: r = CPSC_REG_VSLL;
                `CPSC_IDX_CTRL: r = CPSC_REG_CTRL;
                `CPSC_IDX_ISTAT: r = CPSC_REG_ISTAT;
                `CPSC_IDX_IMASK: r = CPSC_REG_IMASK;
                `CPSC_IDX_RXDAT: r = CPSC_REG_RXDAT;
                default: r = CPSC_REG_NONE;
            endcase
        end
        return r;
    endfunction

    // reserved codes above 100b fall back to the shortest size
    function automatic logic [4:0] cpsc_size(input logic [2:0] code);
        logic [4:0] s;
        case (code)
            3'h0: s = `CPSC_SZ_000;
            3'h1: s = `CPSC_SZ_001;
            3'h2: s = `CPSC_SZ_010;
            3'h3: s = `CPSC_SZ_011;
            3'h4: s = `CPSC_SZ_100;
            default: s = `CPSC_SZ_000;
        endcase
        return s;
    endfunction

    logic [2:0] pins;
    logic bclk_prev_ff;
    logic bclk_rise;
    logic bclk_fall;

    cpsc_sync3 #(.W(3)) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i({link_bclk_i, link_sdi_pri_i, link_sdi_sec_i}),
        .stable_o(pins)
    );

    assign bclk_rise = pins[2] & ~bclk_prev_ff;
    assign bclk_fall = ~pins[2] & bclk_prev_ff;

    // register group
    cpsc_ap_s ap_ff, nxt_ap;
    logic [7:0] rxfmt_ff, nxt_rxfmt, vslh_ff, nxt_vslh, vsll_ff, nxt_vsll;
    logic [7:0] ctrl_ff, nxt_ctrl, istat_ff, nxt_istat, imask_ff, nxt_imask;
    logic [31:0] nxt_hrdata;
    logic nxt_hready, nxt_irq;
    cpsc_mode_e mode;
    // link group
    logic [7:0] cnt_ff, nxt_cnt, drv_ff, nxt_drv;
    logic [15:0] tag_ff, nxt_tag;
    logic sync_ff, nxt_sync, sdo_ff, nxt_sdo;
    logic prdy_ff, nxt_prdy, srdy_ff, nxt_srdy;
    logic [4:0] sbit_ff, nxt_sbit, bit_idx, n_bits, n_len;
    logic [23:0] shift_ff, nxt_shift, rxword_ff, nxt_rxword;
    logic ev_frame, ev_ready, ev_rx;

    assign mode = cpsc_mode_e'(ctrl_ff[1:0]);
    assign n_bits = cpsc_size(rxfmt_ff[`CPSC_BPS_MSB:`CPSC_BPS_LSB]);
    assign n_len = cpsc_size(rxfmt_ff[`CPSC_LEN_MSB:`CPSC_LEN_LSB]);

    always_comb
    begin
        nxt_ap.valid = hsel_i & htrans_i[1] & hready_i;
        nxt_ap.write = hwrite_i;
        nxt_ap.sel = cpsc_decode(haddr_i);
        nxt_rxfmt = rxfmt_ff;
        nxt_vslh = vslh_ff;
        nxt_vsll = vsll_ff;
        nxt_ctrl = ctrl_ff;
        nxt_imask = imask_ff;
        nxt_istat = istat_ff;
        nxt_hrdata = hrdata_o;
        nxt_hready = ~(nxt_ap.valid & ~hwrite_i);
        if (ap_ff.valid && ap_ff.write)
        begin
            case (ap_ff.sel)
                CPSC_REG_RXFMT: nxt_rxfmt = hwdata_i[7:0] & `CPSC_MASK_RXFMT;
                CPSC_REG_VSLH: nxt_vslh = hwdata_i[7:0] & `CPSC_MASK_VSLH;
                CPSC_REG_VSLL: nxt_vsll = hwdata_i[7:0] & `CPSC_MASK_VSLL;
                CPSC_REG_CTRL: nxt_ctrl = hwdata_i[7:0] & `CPSC_MASK_CTRL;
                CPSC_REG_IMASK: nxt_imask = hwdata_i[7:0] & `CPSC_MASK_IRQ;
                default: nxt_ctrl = ctrl_ff;
            endcase
        end
        // read data is taken one cycle late so a write just before is seen
        if (ap_ff.valid && !ap_ff.write)
        begin
            case (ap_ff.sel)
                CPSC_REG_RXFMT: nxt_hrdata = {24'h000000, rxfmt_ff};
                CPSC_REG_VSLH: nxt_hrdata = {24'h000000, vslh_ff[7], prdy_ff, srdy_ff, vslh_ff[4:0]};
                CPSC_REG_VSLL: nxt_hrdata = {24'h000000, vsll_ff};
                CPSC_REG_CTRL: nxt_hrdata = {24'h000000, ctrl_ff};
                CPSC_REG_ISTAT: nxt_hrdata = {24'h000000, istat_ff};
                CPSC_REG_IMASK: nxt_hrdata = {24'h000000, imask_ff};
                CPSC_REG_RXDAT: nxt_hrdata = {8'h00, rxword_ff};
                default: nxt_hrdata = `CPSC_RST_WORD;
            endcase
            if (ap_ff.sel == CPSC_REG_ISTAT)
            begin
                nxt_istat = `CPSC_RST_BYTE;
            end
        end
        // set after clear so an event in the clearing cycle survives
        nxt_istat[`CPSC_IRQ_FRAME] = nxt_istat[`CPSC_IRQ_FRAME] | ev_frame;
        nxt_istat[`CPSC_IRQ_READY] = nxt_istat[`CPSC_IRQ_READY] | ev_ready;
        nxt_istat[`CPSC_IRQ_RXWORD] = nxt_istat[`CPSC_IRQ_RXWORD] | ev_rx;
        nxt_irq = |(istat_ff & imask_ff);
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ap_ff <= '0;
            rxfmt_ff <= `CPSC_RST_BYTE;
            vslh_ff <= `CPSC_RST_BYTE;
            vsll_ff <= `CPSC_RST_BYTE;
            ctrl_ff <= `CPSC_RST_BYTE;
            istat_ff <= `CPSC_RST_BYTE;
            imask_ff <= `CPSC_RST_BYTE;
            hrdata_o <= `CPSC_RST_WORD;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else
        begin
            ap_ff <= nxt_ap;
            rxfmt_ff <= nxt_rxfmt;
            vslh_ff <= nxt_vslh;
            vsll_ff <= nxt_vsll;
            ctrl_ff <= nxt_ctrl;
            istat_ff <= nxt_istat;
            imask_ff <= nxt_imask;
            hrdata_o <= nxt_hrdata;
            hreadyout_o <= nxt_hready;
            hresp_o <= 1'b0;
            irq_o <= nxt_irq;
        end
    end

    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_drv = drv_ff;
        nxt_tag = tag_ff;
        nxt_sync = sync_ff;
        nxt_sdo = sdo_ff;
        nxt_prdy = prdy_ff;
        nxt_srdy = srdy_ff;
        nxt_sbit = sbit_ff;
        nxt_shift = shift_ff;
        nxt_rxword = rxword_ff;
        ev_frame = 1'b0;
        ev_ready = 1'b0;
        ev_rx = 1'b0;
        bit_idx = (drv_ff == `CPSC_POS_FIRST) ? `CPSC_SZ_ZERO : sbit_ff;
        // any mode but the link mode, including the unused code, keeps data low
        if (mode != CPSC_MODE_AC97)
        begin
            nxt_sdo = 1'b0;
        end
        if (mode == CPSC_MODE_OFF)
        begin
            nxt_cnt = `CPSC_POS_FIRST;
            nxt_drv = `CPSC_POS_FIRST;
            nxt_sync = 1'b0;
        end
        else if (bclk_rise)
        begin
            nxt_drv = cnt_ff;
            nxt_cnt = cnt_ff + 8'h01;
            nxt_sync = cnt_ff <= `CPSC_POS_TAG_LAST;
            if (cnt_ff == `CPSC_POS_FIRST)
            begin
                // tag frozen per frame so a mid-frame write cannot tear it
                nxt_tag = {vslh_ff[`CPSC_VF_BIT], 2'h0, vslh_ff[4:0], vsll_ff[7:3], 3'h0};
                ev_frame = 1'b1;
                if (mode == CPSC_MODE_AC97)
                begin
                    nxt_sdo = vslh_ff[`CPSC_VF_BIT];
                end
            end
            else if (mode == CPSC_MODE_AC97)
            begin
                nxt_sdo = (cnt_ff <= `CPSC_POS_TAG_LAST) ? tag_ff[`CPSC_TAG_TOP - cnt_ff[3:0]] : 1'b0;
            end
        end
        else if (bclk_fall && mode == CPSC_MODE_AC97 && drv_ff == `CPSC_POS_FIRST)
        begin
            nxt_prdy = pins[1];
            nxt_srdy = pins[0];
            ev_ready = (pins[1] != prdy_ff) | (pins[0] != srdy_ff);
        end
        else if (bclk_fall && mode == CPSC_MODE_I2S5)
        begin
            nxt_sbit = bit_idx + `CPSC_SZ_ONE;
            if (bit_idx < n_bits)
            begin
                // bits past the data width are padding and ignored
                nxt_shift = (bit_idx == `CPSC_SZ_ZERO) ? {23'h000000, pins[1]} : {shift_ff[22:0], pins[1]};
            end
            if (bit_idx == n_len - `CPSC_SZ_ONE)
            begin
                nxt_rxword = nxt_shift;
                nxt_sbit = `CPSC_SZ_ZERO;
                ev_rx = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            bclk_prev_ff <= 1'b0;
            cnt_ff <= `CPSC_POS_FIRST;
            drv_ff <= `CPSC_POS_FIRST;
            tag_ff <= 16'h0000;
            sync_ff <= 1'b0;
            sdo_ff <= 1'b0;
            prdy_ff <= 1'b0;
            srdy_ff <= 1'b0;
            sbit_ff <= `CPSC_SZ_ZERO;
            shift_ff <= 24'h000000;
            rxword_ff <= 24'h000000;
        end
        else
        begin
            bclk_prev_ff <= pins[2];
            cnt_ff <= nxt_cnt;
            drv_ff <= nxt_drv;
            tag_ff <= nxt_tag;
            sync_ff <= nxt_sync;
            sdo_ff <= nxt_sdo;
            prdy_ff <= nxt_prdy;
            srdy_ff <= nxt_srdy;
            sbit_ff <= nxt_sbit;
            shift_ff <= nxt_shift;
            rxword_ff <= nxt_rxword;
        end
    end

    assign link_sync_o = sync_ff;
    assign link_sdo_o = sdo_ff;

    property p_off_quiet;
        @(posedge clk_i) disable iff (reset_i)
        (mode != CPSC_MODE_AC97) |=> !link_sdo_o;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("sdo driven outside AC-link mode");

    property p_vf_set;
        @(posedge clk_i) disable iff (reset_i)
        (bclk_rise && mode == CPSC_MODE_AC97 && cnt_ff == 8'h00 && vslh_ff[7]) |=> link_sdo_o && link_sync_o;
    endproperty
    a_vf_set: assert property (p_vf_set) else $error("valid frame not tagged");

    property p_vf_clr;
        @(posedge clk_i) disable iff (reset_i)
        (bclk_rise && mode == CPSC_MODE_AC97 && cnt_ff == 8'h00 && !vslh_ff[7]) |=> !link_sdo_o;
    endproperty
    a_vf_clr: assert property (p_vf_clr) else $error("invalid frame tagged valid");

    property p_ready;
        @(posedge clk_i) disable iff (reset_i)
        (bclk_fall && mode == CPSC_MODE_AC97 && drv_ff == 8'h00) |=> (prdy_ff == $past(pins[1])) && (srdy_ff == $past(pins[0]));
    endproperty
    a_ready: assert property (p_ready) else $error("codec ready not captured");

    property p_slot3;
        @(posedge clk_i) disable iff (reset_i)
        (bclk_rise && mode == CPSC_MODE_AC97 && cnt_ff == 8'h03) |=> link_sdo_o == $past(tag_ff[12]);
    endproperty
    a_slot3: assert property (p_slot3) else $error("slot 3 tag wrong");

    property p_slot8;
        @(posedge clk_i) disable iff (reset_i)
        (bclk_rise && mode == CPSC_MODE_AC97 && cnt_ff == 8'h08) |=> link_sdo_o == $past(tag_ff[7]);
    endproperty
    a_slot8: assert property (p_slot8) else $error("slot 8 tag wrong");

    property p_rx_slot;
        @(posedge clk_i) disable iff (reset_i)
        ev_rx |-> ##1 (istat_ff[2] && sbit_ff == 5'h00) ##1 istat_ff[2] || $past(ap_ff.valid);
    endproperty
    a_rx_slot: assert property (p_rx_slot) else $error("slot end not flagged");
endmodule

// >>> hw/cpsc_defs.svh
/*
 * Constants of the codec port slot configuration block: register indices,
 * field positions, reset values, frame positions and slot size codes.
 * Assumes inclusion by bare name from cpsc_top and the test bench.
 */
`ifndef CPSC_DEFS_SVH
`define CPSC_DEFS_SVH

// register indices; byte address is four times the index
`define CPSC_IDX_RXFMT 16'hFFD6
`define CPSC_IDX_VSLH 16'hFFD7
`define CPSC_IDX_VSLL 16'hFFD8
`define CPSC_IDX_CTRL 16'h0100
`define CPSC_IDX_ISTAT 16'h0101
`define CPSC_IDX_IMASK 16'h0102
`define CPSC_IDX_RXDAT 16'h0103

`define CPSC_RST_BYTE 8'h00
`define CPSC_RST_WORD 32'h0000_0000
`define CPSC_MASK_RXFMT 8'h3F
`define CPSC_MASK_VSLH 8'h9F
`define CPSC_MASK_VSLL 8'hF8
`define CPSC_MASK_CTRL 8'h03
`define CPSC_MASK_IRQ 8'h07

`define CPSC_VF_BIT 7
`define CPSC_PRDY_BIT 6
`define CPSC_SRDY_BIT 5
`define CPSC_BPS_MSB 5
`define CPSC_BPS_LSB 3
`define CPSC_LEN_MSB 2
`define CPSC_LEN_LSB 0

`define CPSC_IRQ_FRAME 0
`define CPSC_IRQ_READY 1
`define CPSC_IRQ_RXWORD 2

// frame layout on the link, in bit-clock positions
`define CPSC_POS_FIRST 8'h00
`define CPSC_POS_TAG_LAST 8'h0F
`define CPSC_TAG_TOP 4'hF

// slot size codes, bits or serial-clock cycles
`define CPSC_SZ_000 5'h08
`define CPSC_SZ_001 5'h10
`define CPSC_SZ_010 5'h12
`define CPSC_SZ_011 5'h14
`define CPSC_SZ_100 5'h18
`define CPSC_SZ_ONE 5'h01
`define CPSC_SZ_ZERO 5'h00

`endif

// >>> hw/cpsc_pkg.sv
/*
 * Types of the codec port slot configuration block.
 * Assumes cpsc_defs.svh is on the include path.
 */
package cpsc_pkg;
    typedef enum logic [1:0] {
        CPSC_MODE_OFF = 2'h0,
        CPSC_MODE_AC97 = 2'h1,
        CPSC_MODE_I2S5 = 2'h3
    } cpsc_mode_e;

    typedef enum logic [2:0] {
        CPSC_REG_NONE,
        CPSC_REG_RXFMT,
        CPSC_REG_VSLH,
        CPSC_REG_VSLL,
        CPSC_REG_CTRL,
        CPSC_REG_ISTAT,
        CPSC_REG_IMASK,
        CPSC_REG_RXDAT
    } cpsc_reg_e;

    typedef struct packed {
        logic valid;
        logic write;
        cpsc_reg_e sel;
    } cpsc_ap_s;
endpackage

// >>> hw/cpsc_sync3.sv
/*
 * Three-flop input synchroniser; the output follows once flops two and
 * three agree. Assumes asynchronous inputs and clk_i of the block.
 */
`timescale 1ns/10ps
module cpsc_sync3 #(
    parameter int W = 3
) (
    input wire logic clk_i, // block clock
    input wire logic reset_i, // async reset, high
    input wire logic [W-1:0] async_i, // raw pins
    output logic [W-1:0] stable_o // filtered level
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] nxt_stable;

    always_comb
    begin
        nxt_stable = stable_o;
        for (int i = 0; i < W; i++)
        begin
            if (s2_ff[i] == s3_ff[i])
            begin
                nxt_stable[i] = s3_ff[i];
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            stable_o <= '0;
        end
        else
        begin
            s1_ff <= async_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            stable_o <= nxt_stable;
        end
    end
endmodule

// >>> test/cpsc_codec_model.sv
/*
 * Behavioural primary and secondary codec on the far side of the link.
 * Assumes the block's frame sync output is fed back to align the frame.
 */
`timescale 1ns/10ps
module cpsc_codec_model (
    input wire logic run_i, // bit clock runs while high
    input wire logic [23:0] word_i, // slot word, msb first
    input wire logic [4:0] slen_i, // slot length in bit clocks
    input wire logic sec_ready_i, // secondary ready level
    input wire logic sync_i, // frame sync from the block
    output logic bclk_o, // codec serial clock
    output logic sdi_pri_o, // primary serial data
    output logic sdi_sec_o // secondary serial data
);
    int pos;
    logic seen;
    // odd start offset keeps the bit clock out of phase with clk_i
    initial
    begin
        bclk_o = 1'h0;
        sdi_pri_o = 1'h0;
        sdi_sec_o = 1'h1;
        pos = 0;
        seen = 1'h0;
        #13;
        forever #160 bclk_o = run_i ? ~bclk_o : 1'h0;
    end
    // sync seen first at the second bit, so the frame restarts at 1
    always @(posedge bclk_o)
    begin
        pos = (sync_i && !seen) ? 1 : (pos + 1) % 256;
        seen = sync_i;
        sdi_pri_o = word_i[23 - (pos % slen_i)];
        sdi_sec_o = (pos == 0) ? sec_ready_i : ~sdi_pri_o;
    end
endmodule

// >>> test/codec_port_slot_config_test.sv
/*
 * Self-checking bench of cpsc_top: AHB-Lite master tasks, codec model,
 * slot 0 tag capture. Assumes the design and model files compile first.
 */
`timescale 1ns/10ps
`include "cpsc_defs.svh"
module codec_port_slot_config_test;
    logic clk_i = 1'h0, reset_i = 1'h1, hsel_i = 1'h0, hwrite_i = 1'h0, run = 1'h0, sec_rdy = 1'h0;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, rd, rnd = 32'h4522;
    logic [1:0] htrans_i = 2'h0;
    logic [23:0] word = 24'h800000;
    logic [4:0] slen = 5'h18;
    logic [15:0] tag;
    logic hreadyout_o, hresp_o, irq_o, bclk, sdi_pri, sdi_sec, link_sync_o, link_sdo_o;
    int mismatches = 0, checks = 0, cyc = 0;
    logic [15:0] idx_tab [0:7] = '{`CPSC_IDX_RXFMT, `CPSC_IDX_VSLH, `CPSC_IDX_VSLL, `CPSC_IDX_CTRL,
        `CPSC_IDX_ISTAT, `CPSC_IDX_IMASK, `CPSC_IDX_RXDAT, 16'h0200};
    logic [7:0] msk_tab [0:7] = '{`CPSC_MASK_RXFMT, `CPSC_MASK_VSLH, `CPSC_MASK_VSLL, `CPSC_MASK_CTRL,
        8'h00, `CPSC_MASK_IRQ, 8'h00, 8'h00};

    always #20 clk_i = ~clk_i;

    cpsc_top i_cpsc_top (.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .irq_o(irq_o), .link_bclk_i(bclk), .link_sdi_pri_i(sdi_pri), .link_sdi_sec_i(sdi_sec),
        .link_sync_o(link_sync_o), .link_sdo_o(link_sdo_o));

    cpsc_codec_model i_cpsc_codec_model (.run_i(run), .word_i(word), .slen_i(slen),
        .sec_ready_i(sec_rdy), .sync_i(link_sync_o), .bclk_o(bclk), .sdi_pri_o(sdi_pri),
        .sdi_sec_o(sdi_sec));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [15:0] exp_tag(input logic [7:0] h, input logic [7:0] l);
        return {h[7], 2'h0, h[4:0], l[7:3], 3'h0};
    endfunction

    function automatic int bits_of(input logic [2:0] c);
        case (c)
            3'h1: return 16;
            3'h2: return 18;
            3'h3: return 20;
            3'h4: return 24;
            default: return 8;
        endcase
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wait_ready();
        @(posedge clk_i);
        while (hreadyout_o !== 1'h1) @(posedge clk_i);
    endtask

    task automatic ahb_write(input logic [15:0] idx, input logic [31:0] d);
        hsel_i <= 1'h1;
        htrans_i <= 2'h2;
        haddr_i <= {14'h0, idx, 2'h0};
        hwrite_i <= 1'h1;
        wait_ready();
        hsel_i <= 1'h0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        wait_ready();
    endtask

    task automatic ahb_read(input logic [15:0] idx, output logic [31:0] d);
        hsel_i <= 1'h1;
        htrans_i <= 2'h2;
        haddr_i <= {14'h0, idx, 2'h0};
        hwrite_i <= 1'h0;
        wait_ready();
        hsel_i <= 1'h0;
        htrans_i <= 2'h0;
        wait_ready();
        d = hrdata_o;
    endtask

    task automatic wait_frames(input int n);
        repeat (n) @(posedge link_sync_o);
        @(posedge clk_i);
    endtask

    // sample mid-bit: eight clk_i cycles to one bit clock
    task automatic capture_tag(output logic [15:0] t);
        @(posedge link_sync_o);
        repeat (4) @(posedge clk_i);
        for (int i = 15; i >= 0; i--)
        begin
            t[i] = link_sdo_o;
            repeat (8) @(posedge clk_i);
        end
    endtask

    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (3) @(posedge clk_i);
        reset_i <= 1'h0;
        @(posedge clk_i);
        check("irq after reset", {31'h0, irq_o}, 32'h0);
        check("okay response", {31'h0, hresp_o}, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            ahb_read(idx_tab[i], rd);
            check("reset value", rd, 32'h0);
        end
        // status skipped: its write behaviour is not defined
        for (int i = 0; i < 8; i++)
        begin
            rnd = lfsr(rnd);
            if (i == 4)
                continue;
            ahb_write(idx_tab[i], rnd);
            ahb_read(idx_tab[i], rd);
            check("readback", rd, {24'h0, rnd[7:0] & msk_tab[i]});
        end
        ahb_write(`CPSC_IDX_CTRL, 32'h0);
        rnd = lfsr(rnd);
        run <= 1'h1;
        ahb_write(`CPSC_IDX_IMASK, 32'h0);
        ahb_write(`CPSC_IDX_VSLL, {24'h0, rnd[7:0]});
        ahb_write(`CPSC_IDX_VSLH, {24'h0, 3'h4, rnd[12:8]});
        ahb_write(`CPSC_IDX_CTRL, 32'h1);
        wait_frames(2);
        capture_tag(tag);
        check("valid tag", {16'h0, tag}, {16'h0, exp_tag({3'h4, rnd[12:8]}, rnd[7:0])});
        ahb_read(`CPSC_IDX_VSLH, rd);
        check("ready flags", rd, {24'h0, 3'h6, rnd[12:8]});
        check("irq masked", {31'h0, irq_o}, 32'h0);
        ahb_write(`CPSC_IDX_IMASK, 32'h2);
        repeat (3) @(posedge clk_i);
        check("irq unmasked", {31'h0, irq_o}, 32'h1);
        ahb_read(`CPSC_IDX_ISTAT, rd);
        check("ready change", rd & 32'h2, 32'h2);
        repeat (3) @(posedge clk_i);
        check("irq cleared", {31'h0, irq_o}, 32'h0);
        word <= 24'h0;
        sec_rdy <= 1'h1;
        ahb_write(`CPSC_IDX_VSLH, 32'h0);
        ahb_write(`CPSC_IDX_VSLL, 32'h0);
        ahb_write(`CPSC_IDX_IMASK, 32'h1);
        wait_frames(2);
        capture_tag(tag);
        check("invalid tag", {16'h0, tag}, 32'h0);
        check("frame irq", {31'h0, irq_o}, 32'h1);
        ahb_read(`CPSC_IDX_VSLH, rd);
        check("ready flags", rd, 32'h20);
        // port no longer in the link mode: the byte must not reach the wire
        ahb_write(`CPSC_IDX_VSLH, 32'h9F);
        ahb_write(`CPSC_IDX_CTRL, 32'h3);
        wait_frames(1);
        capture_tag(tag);
        check("tag outside link mode", {16'h0, tag}, 32'h0);
        for (int c = 0; c < 6; c++)
        begin
            rnd = lfsr(rnd);
            word <= rnd[23:0];
            slen <= 5'(bits_of(3'(c)));
            ahb_write(`CPSC_IDX_RXFMT, {26'h0, 3'(c), 3'(c)});
            wait_frames(2);
            // let the first slot of the frame finish before reading
            repeat (232) @(posedge clk_i);
            ahb_read(`CPSC_IDX_RXDAT, rd);
            check("rx word", rd, {8'h0, rnd[23:0]} >> (24 - bits_of(3'(c))));
        end
        ahb_write(`CPSC_IDX_CTRL, 32'h0);
        repeat (4) @(posedge clk_i);
        check("sync idle", {31'h0, link_sync_o}, 32'h0);
        check("okay at end", {31'h0, hresp_o}, 32'h0);
        run <= 1'h0;
        give_verdict();
    end
endmodule
